// ---- design/rsr_exec_pkg.sv ----
// shared constants and carriers for the rotate / subtract / return executor
package rsr_exec_pkg;

    // ------------------------------------------------------------------
    // widths and RAM depth
    // ------------------------------------------------------------------
    localparam int INSTR_W = 16;
    localparam int NIB_W   = 4;
    localparam int ADDR_W  = 7;
    localparam int PC_W    = 11;
    localparam int RAM_N   = 128;

    // ------------------------------------------------------------------
    // opcode prefixes and field positions
    // ------------------------------------------------------------------
    localparam logic [8:0]  OP_ROTATE_RIGHT   = 9'h09B;
    localparam logic [7:0]  OP_SUB_MEM        = 8'h14;
    localparam logic [7:0]  OP_SUB_MEM_WB     = 8'h16;
    localparam logic [7:0]  OP_SUB_IMM        = 8'h0E;
    localparam logic [7:0]  OP_SUB_IMM_WB     = 8'h0F;
    localparam logic [15:0] OP_RETURN         = 16'h0200;
    localparam int PFX9_LSB = 7;
    localparam int PFX8_LSB = 8;
    localparam int IMM_LSB  = 4;
    localparam int WREG_LSB = 0;
    localparam int MEM_LSB  = 0;
    localparam int SPARE_BIT = 7;

    // ------------------------------------------------------------------
    // reset values and counter step
    // ------------------------------------------------------------------
    localparam logic [NIB_W-1:0] ACC_RST = 4'h0;
    localparam logic [PC_W-1:0]  PC_RST  = 11'h000;
    localparam logic [PC_W-1:0]  PC_STEP = 11'h001;

    // one data-RAM write
    typedef struct packed {
        logic              we;
        logic [ADDR_W-1:0] addr;
        logic [NIB_W-1:0]  data;
    } ram_write_t;

    // result register plus carry flag
    typedef struct packed {
        logic [NIB_W-1:0] acc;
        logic             carry;
    } alu_state_t;

    // decoded instruction class, one-hot
    typedef enum logic [5:0] {
        OPC_NONE   = 6'b000001,
        OPC_ROT    = 6'b000010,
        OPC_RET    = 6'b000100,
        OPC_SUBM   = 6'b001000,
        OPC_SUBMWB = 6'b010000,
        OPC_SUBI   = 6'b100000
    } opclass_t;

endpackage

// ---- design/rsr_exec.sv ----
// executor for rotate-right, subroutine return and subtract-with-borrow
`timescale 1ns/1ns
module rsr_exec
    import rsr_exec_pkg::*;
(
    input  wire logic                SYS_CLK,
    input  wire logic                RST,
    input  wire logic                INSTR_VALID,
    input  wire logic [INSTR_W-1:0]  INSTR,
    input  wire logic [PC_W-1:0]     STACK_TOP,
    input  wire ram_write_t          LOAD,
    input  wire logic                PRESET_EN,
    input  wire alu_state_t          PRESET,
    input  wire logic [ADDR_W-1:0]   PEEK_ADDR,
    output logic [NIB_W-1:0]         PEEK_DATA,
    output logic [NIB_W-1:0]         RESULT_REGISTER,
    output logic                     CARRY_FLAG,
    output logic                     ZERO_FLAG,
    output logic [PC_W-1:0]          PROGRAM_COUNTER,
    output logic                     STACK_POP,
    output logic                     DONE,
    output ram_write_t               RAM_WRITE
);

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // borrow in bit 4, difference in bits 3:0
    function automatic logic [NIB_W:0] sub_borrow(
        input logic [NIB_W-1:0] a,
        input logic [NIB_W-1:0] b,
        input logic             c);
        logic [NIB_W:0] d;
        d = {1'b0, a} - {1'b0, b} - {{NIB_W{1'b0}}, c};
        return d;
    endfunction

    function automatic logic is_zero(input logic [NIB_W-1:0] v);
        return v == '0;
    endfunction

    // ------------------------------------------------------------------
    // storage: data RAM, working registers are its low 16 words
    // ------------------------------------------------------------------
    logic [NIB_W-1:0] ram [RAM_N];

    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    opclass_t          opc;
    logic              imm_wb;
    logic              mem_wb;
    logic [ADDR_W-1:0] mem_addr;
    logic [ADDR_W-1:0] wreg_addr;
    logic [NIB_W-1:0]  imm;
    logic [7:0]        pfx8;

    assign pfx8      = INSTR[INSTR_W-1:PFX8_LSB];
    assign mem_addr  = INSTR[MEM_LSB +: ADDR_W];
    assign imm       = INSTR[IMM_LSB +: NIB_W];
    assign wreg_addr = {3'h0, INSTR[WREG_LSB +: NIB_W]};

    always_comb begin
        opc    = OPC_NONE;
        imm_wb = 1'b0;
        mem_wb = 1'b0;
        if (INSTR[INSTR_W-1:PFX9_LSB] == OP_ROTATE_RIGHT) begin
            opc = OPC_ROT;
        end else if (INSTR == OP_RETURN) begin
            opc = OPC_RET;
        end else if (pfx8 == OP_SUB_MEM && !INSTR[SPARE_BIT]) begin
            opc = OPC_SUBM;
        end else if (pfx8 == OP_SUB_MEM_WB && !INSTR[SPARE_BIT]) begin
            opc    = OPC_SUBMWB;
            mem_wb = 1'b1;
        end else if (pfx8 == OP_SUB_IMM || pfx8 == OP_SUB_IMM_WB) begin
            opc    = OPC_SUBI;
            imm_wb = pfx8 == OP_SUB_IMM_WB;
        end
    end

    // ------------------------------------------------------------------
    // datapath
    // ------------------------------------------------------------------
    logic [NIB_W-1:0]  operand;
    logic [NIB_W:0]    diff;
    logic [NIB_W-1:0]  next_acc;
    logic              next_carry;
    logic              exec;
    ram_write_t        next_write;

    assign exec    = INSTR_VALID && opc != OPC_NONE && opc != OPC_RET;
    assign operand = ram[(opc == OPC_SUBI) ? wreg_addr : mem_addr];

    always_comb begin
        diff       = '0;
        next_acc   = RESULT_REGISTER;
        next_carry = CARRY_FLAG;
        next_write = '0;
        unique case (opc)
            OPC_ROT: begin
                next_acc   = {CARRY_FLAG, operand[NIB_W-1:1]};
                next_carry = operand[0];
                next_write = '{we: 1'b1, addr: mem_addr,
                               data: next_acc};
            end
            OPC_SUBM, OPC_SUBMWB: begin
                // binary only, no decimal adjust
                diff       = sub_borrow(operand, RESULT_REGISTER,
                                        CARRY_FLAG);
                next_acc   = diff[NIB_W-1:0];
                next_carry = diff[NIB_W];
                next_write = '{we: mem_wb, addr: mem_addr,
                               data: diff[NIB_W-1:0]};
            end
            OPC_SUBI: begin
                diff       = sub_borrow(operand, imm, CARRY_FLAG);
                next_acc   = diff[NIB_W-1:0];
                next_carry = diff[NIB_W];
                next_write = '{we: imm_wb, addr: wreg_addr,
                               data: diff[NIB_W-1:0]};
            end
            OPC_NONE, OPC_RET: begin
            end
        endcase
    end

    // ------------------------------------------------------------------
    // result register and flags
    // ------------------------------------------------------------------
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            RESULT_REGISTER <= ACC_RST;
            CARRY_FLAG      <= 1'b0;
            ZERO_FLAG       <= 1'b1;
        end else if (exec) begin
            RESULT_REGISTER <= next_acc;
            CARRY_FLAG      <= next_carry;
            ZERO_FLAG       <= is_zero(next_acc);
        end else if (PRESET_EN) begin
            RESULT_REGISTER <= PRESET.acc;
            CARRY_FLAG      <= PRESET.carry;
            ZERO_FLAG       <= is_zero(PRESET.acc);
        end
    end

    // ------------------------------------------------------------------
    // data RAM; execution write beats a load to keep the result coherent
    // ------------------------------------------------------------------
    always_ff @(posedge SYS_CLK) begin
        if (exec && next_write.we) begin
            ram[next_write.addr] <= next_write.data;
        end else if (LOAD.we) begin
            ram[LOAD.addr] <= LOAD.data;
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            RAM_WRITE <= '0;
            PEEK_DATA <= '0;
        end else begin
            RAM_WRITE <= exec ? next_write : '0;
            PEEK_DATA <= ram[PEEK_ADDR];
        end
    end

    // ------------------------------------------------------------------
    // program counter; other instructions just step past
    // ------------------------------------------------------------------
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            PROGRAM_COUNTER <= PC_RST;
            STACK_POP       <= 1'b0;
            DONE            <= 1'b0;
        end else begin
            STACK_POP <= INSTR_VALID && opc == OPC_RET;
            DONE      <= INSTR_VALID;
            if (INSTR_VALID && opc == OPC_RET) begin
                PROGRAM_COUNTER <= STACK_TOP;
            end else if (INSTR_VALID) begin
                PROGRAM_COUNTER <= PROGRAM_COUNTER + PC_STEP;
            end
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);

    a_rotate_result: assert property (
        INSTR_VALID && opc == OPC_ROT |=> RESULT_REGISTER ==
            {$past(CARRY_FLAG), $past(operand[NIB_W-1:1])}
            && CARRY_FLAG == $past(operand[0]))
        else $error("rotate result or carry wrong");
    a_rotate_store: assert property (
        INSTR_VALID && opc == OPC_ROT |=> RAM_WRITE.we
            && RAM_WRITE.addr == $past(mem_addr)
            && RAM_WRITE.data == RESULT_REGISTER)
        else $error("rotate not written back");
    a_rotate_prefix: assert property (
        INSTR_VALID && INSTR[INSTR_W-1:PFX9_LSB] == OP_ROTATE_RIGHT
            |=> DONE && RAM_WRITE.we)
        else $error("rotate not done in one cycle");
    a_return_pc: assert property (
        INSTR_VALID && INSTR == OP_RETURN
            |=> PROGRAM_COUNTER == $past(STACK_TOP) && STACK_POP)
        else $error("return did not load counter");
    a_sub_mem_only: assert property (
        INSTR_VALID && opc == OPC_SUBM |=> !RAM_WRITE.we
            && {CARRY_FLAG, RESULT_REGISTER} == 5'($past(operand)
            - $past(RESULT_REGISTER) - $past(CARRY_FLAG)))
        else $error("memory subtract wrong");
    a_sub_mem_wb: assert property (
        INSTR_VALID && opc == OPC_SUBMWB |=> RAM_WRITE.we
            && RAM_WRITE.data == RESULT_REGISTER
            && RAM_WRITE.addr == $past(mem_addr))
        else $error("memory subtract not written back");
    a_sub_imm: assert property (
        INSTR_VALID && pfx8 == OP_SUB_IMM |=> !RAM_WRITE.we
            && {CARRY_FLAG, RESULT_REGISTER} == 5'($past(operand)
            - $past(imm) - $past(CARRY_FLAG)))
        else $error("immediate subtract wrong");
    a_sub_imm_wb: assert property (
        INSTR_VALID && pfx8 == OP_SUB_IMM_WB |=> RAM_WRITE.we
            && RAM_WRITE.addr == $past(wreg_addr)
            && RAM_WRITE.data == RESULT_REGISTER)
        else $error("immediate subtract not written back");
    a_zero_flag: assert property (
        exec |=> ZERO_FLAG == (RESULT_REGISTER == 4'h0))
        else $error("zero flag wrong");
    a_flags_hold: assert property (
        !exec && !PRESET_EN |=> $stable(CARRY_FLAG) && $stable(ZERO_FLAG))
        else $error("flags moved without instruction");

    c_rotate: cover property (INSTR_VALID && opc == OPC_ROT);
    c_borrow: cover property (exec && opc == OPC_SUBI ##1 CARRY_FLAG);
    c_return: cover property (INSTR_VALID && opc == OPC_RET);
    c_back_to_back: cover property (exec ##1 exec);

endmodule // rsr_exec

// ---- tb/ret_stack_model.sv ----
// behavioural return stack that supplies the executor's stack top
`timescale 1ns/1ns
module ret_stack_model
    import rsr_exec_pkg::*;
(
    input  wire logic            clk,
    input  wire logic            pop,
    output logic [PC_W-1:0]      top
);
    // ------------------------------------------------------------------
    // stack top
    // ------------------------------------------------------------------
    // each pop moves to a fresh address, so a stale top is caught
    logic [PC_W-1:0] stk = 11'h2C5;
    assign top = stk;
    always @(posedge clk) begin
        if (pop) begin
            stk <= {stk[PC_W-2:0], stk[PC_W-1] ^ stk[PC_W-3]};
        end
    end
endmodule // ret_stack_model

// ---- tb/tb_rsr_exec.sv ----
// self-checking bench for the rotate / subtract / return executor
`timescale 1ns/1ns
module tb_rsr_exec;
    import rsr_exec_pkg::*;
    logic               sys_clk = 1'b0;
    logic               rst = 1'b1;
    logic               valid = 1'b0;
    logic [INSTR_W-1:0] instr = '0;
    logic [PC_W-1:0]    stack_top;
    ram_write_t         load = '0;
    logic               preset_en = 1'b0;
    alu_state_t         preset = '0;
    logic [ADDR_W-1:0]  peek_addr = '0;
    logic [NIB_W-1:0]   peek_data, acc;
    logic               carry, zero, pop, done, e_we, e_pop;
    logic [PC_W-1:0]    pc;
    ram_write_t         ram_wr;
    int                 fails = 0;
    int                 checks_done = 0;
    logic [NIB_W-1:0]   ram [RAM_N];
    logic [NIB_W-1:0]   e_acc = ACC_RST;
    logic               e_carry = 1'b0;
    logic [PC_W-1:0]    e_pc = PC_RST;
    logic [ADDR_W-1:0]  e_wa;

    always #4 sys_clk = ~sys_clk;

    rsr_exec u_rsr_exec (.SYS_CLK(sys_clk), .RST(rst), .INSTR_VALID(valid),
        .INSTR(instr), .STACK_TOP(stack_top), .LOAD(load),
        .PRESET_EN(preset_en), .PRESET(preset), .PEEK_ADDR(peek_addr),
        .PEEK_DATA(peek_data), .RESULT_REGISTER(acc), .CARRY_FLAG(carry),
        .ZERO_FLAG(zero), .PROGRAM_COUNTER(pc), .STACK_POP(pop),
        .DONE(done), .RAM_WRITE(ram_wr));
    ret_stack_model u_ret_stack_model (.clk(sys_clk), .pop(pop),
        .top(stack_top));

    // ------------------------------------------------------------------
    // checking and expectations
    // ------------------------------------------------------------------
    task automatic check(input logic ok, input string what);
        checks_done++;
        if (ok !== 1'b1) begin
            fails++;
            $display("Error at %0t: %s", $time, what);
        end
    endtask

    function automatic void model(input logic [15:0] w, input logic [10:0] t);
        logic [ADDR_W-1:0] a;
        logic [4:0]        d;
        a = w[6:0];
        e_we = 1'b0;
        e_pop = 1'b0;
        e_pc = e_pc + PC_STEP;
        if (w[15:7] == OP_ROTATE_RIGHT) begin
            d = {ram[a][0], e_carry, ram[a][3:1]};
            {e_carry, e_acc} = d;
            ram[a] = e_acc;
            e_we = 1'b1;
            e_wa = a;
        end else if (w == OP_RETURN) begin
            e_pc = t;
            e_pop = 1'b1;
        end else if (w[15:8] inside {OP_SUB_MEM, OP_SUB_MEM_WB} && !w[7] ||
                     w[15:8] inside {OP_SUB_IMM, OP_SUB_IMM_WB}) begin
            // immediate forms address working register n at ram n
            if (!w[12]) a = {3'h0, w[3:0]};
            d = {1'b0, ram[a]} - (w[12] ? {1'b0, e_acc} : {1'b0, w[7:4]})
                - {4'h0, e_carry};
            {e_carry, e_acc} = d;
            if (w[12] ? w[9] : w[8]) begin
                ram[a] = e_acc;
                e_we = 1'b1;
                e_wa = a;
            end
        end
    endfunction

    task automatic run(input logic [INSTR_W-1:0] w);
        instr = w;
        valid = 1'b1;
        model(w, stack_top);
        @(negedge sys_clk);
        check(acc === e_acc && carry === e_carry && zero === (e_acc == 4'h0),
              "result or flags");
        check(pc === e_pc && done === 1'b1 && pop === e_pop, "counter");
        check(ram_wr.we === e_we && (!e_we || ram_wr.addr === e_wa &&
              ram_wr.data === e_acc), "memory write");
    endtask

    task automatic idle();
        valid = 1'b0;
        @(negedge sys_clk);
        check(done === 1'b0 && pop === 1'b0 && ram_wr.we === 1'b0, "pulses");
    endtask

    task automatic set_alu(input logic [3:0] a, input logic c);
        // a held valid would re-run the last instruction here
        valid = 1'b0;
        preset_en = 1'b1;
        preset = '{acc: a, carry: c};
        @(negedge sys_clk);
        preset_en = 1'b0;
        e_acc = a;
        e_carry = c;
    endtask

    function automatic logic [15:0] rand_instr();
        logic [6:0] a;
        a = 7'($urandom);
        case ($urandom % 7)
            0: return {OP_ROTATE_RIGHT, a};
            1: return OP_RETURN;
            2: return {OP_SUB_MEM, 1'b0, a};
            3: return {OP_SUB_MEM_WB, 1'b0, a};
            4: return {OP_SUB_IMM, 8'($urandom)};
            5: return {OP_SUB_IMM_WB, 8'($urandom)};
            default: return {8'hFF, 8'($urandom)};
        endcase
    endfunction

    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        void'($urandom(71));
        repeat (16) @(negedge sys_clk);
        rst = 1'b0;
        check(acc === ACC_RST && zero === 1'b1 && pc === PC_RST, "reset");
        for (int i = 0; i < RAM_N; i++) begin
            ram[i] = (i == 5) ? 4'h1 : 4'($urandom);
            load = '{we: 1'b1, addr: 7'(i), data: ram[i]};
            @(negedge sys_clk);
        end
        load.we = 1'b0;
        set_alu(4'h0, 1'b0);
        run({OP_ROTATE_RIGHT, 7'h05});
        run({OP_ROTATE_RIGHT, 7'h05});
        run(OP_RETURN);
        run(OP_RETURN);
        set_alu(4'hF, 1'b1);
        run({OP_SUB_MEM, 1'b0, 7'h7F});
        run({OP_SUB_MEM_WB, 1'b0, 7'h05});
        run({OP_SUB_IMM, 4'hF, 4'h5});
        run({OP_SUB_IMM_WB, 4'h0, 4'h5});
        run({OP_SUB_MEM, 1'b1, 7'h05});
        run(16'hFFFF);
        idle();
        set_alu(ram[9], 1'b0);
        run({OP_SUB_MEM, 1'b0, 7'h09});
        repeat (400) begin
            run(rand_instr());
            if ($urandom % 8 == 0) begin
                idle();
                set_alu(4'($urandom), 1'($urandom));
            end
        end
        idle();
        // mid-run reset; data memory keeps its contents
        rst = 1'b1;
        @(negedge sys_clk);
        rst = 1'b0;
        e_acc = ACC_RST;
        e_carry = 1'b0;
        e_pc = PC_RST;
        check(acc === ACC_RST && carry === 1'b0 && zero === 1'b1 &&
              pc === PC_RST && done === 1'b0 && ram_wr.we === 1'b0,
              "mid-run reset");
        run({OP_ROTATE_RIGHT, 7'h05});
        idle();
        for (int i = 0; i < RAM_N; i++) begin
            peek_addr = 7'(i);
            @(negedge sys_clk);
            check(peek_data === ram[i], "ram contents");
        end
        print_verdict();
    end

    // hang guard, well beyond the roughly 800 cycles the run needs
    initial begin
        #200000;
        fails++;
        print_verdict();
    end
endmodule // tb_rsr_exec
